// ===== rtl/ccs_axil_slave.sv
`timescale 1ns/1ns
module ccs_axil_slave
    import ccs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    ccs_reg_if.slave rif
);
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] awaddr_ff;
    logic [7:0] wdata_ff;
    logic wlane_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic wr_go;

    // ****************************************
    // Write channel
    // ****************************************
    // Address and data may come in either order
    assign awready = !aw_got_ff && !bvalid_ff;
    assign wready = !w_got_ff && !bvalid_ff;
    assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
    // Lane 0 off means nothing is stored
    assign rif.wr_en = wr_go && wlane_ff;
    assign rif.wr_addr = awaddr_ff;
    assign rif.wr_data = wdata_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;

    // Capture address and data, answer one cycle after both are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            wlane_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
        end else begin
            if (awvalid && awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= wdata[7:0];
                wlane_ff <= wstrb[0];
            end
            if (wr_go) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= rif.wr_err ? 2'h2 : 2'h0;
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    assign arready = !rvalid_ff;
    assign rif.rd_en = arvalid && arready;
    assign rif.rd_addr = araddr;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    // Reads have no side effect, so data is taken straight at the handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'h0;
        end else if (rif.rd_en) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h00_0000, rif.rd_data};
            rresp_ff <= rif.rd_err ? 2'h2 : 2'h0;
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule

// ===== rtl/ccs_pkg.sv
package ccs_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int OST_TIME_NS = 409600;
    localparam int OST_CYCLES = (OST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_TIME_NS = 51200;
    localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFF_PROC_CLK_CTRL = 8'h00;
    localparam logic [7:0] OFF_INT_OSC_MODE = 8'h04;
    localparam logic [7:0] OFF_CPU_CLK_STATUS = 8'h08;
    localparam logic [7:0] OFF_PROT_CMD = 8'h0C;
    localparam logic [7:0] OFF_STANDBY_CTRL = 8'h10;
    localparam logic [7:0] OFF_CLK_RUN_STATUS = 8'h14;

    // ****************************************
    // Reset values and field layout
    // ****************************************
    localparam logic [7:0] RST_PROC_CLK_CTRL = 8'h03;
    localparam logic [7:0] RST_INT_OSC_MODE = 8'h00;
    localparam logic [7:0] CPU_STATUS_INT_OSC = 8'h01;
    localparam logic [7:0] PROC_CLK_CTRL_WMASK = 8'hEF;
    localparam int BIT_MAIN_OSC_STOP = 6;
    localparam int BIT_CLK_SRC_FLAG = 4;
    localparam int BIT_SUB_SEL = 3;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 3;
    localparam int BIT_INT_OSC_STOP = 0;
    localparam int BIT_INT_OSC_CPU_FLAG = 0;
    localparam int STBY_W = 3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {CPU_OST, CPU_MAIN, CPU_SUB, CPU_INT} ccs_cpu_src_e;
    typedef enum logic [2:0] {SB_NORMAL, SB_HALT, SB_LIGHT_IDLE_STANDBY, SB_DEEP_IDLE_STANDBY, SB_STOP} ccs_standby_e;
endpackage

// ===== rtl/ccs_reg_if.sv
`timescale 1ns/1ns
interface ccs_reg_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_err;
    logic wr_err;

    modport slave (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                   input rd_data, rd_err, wr_err);
    modport core (input wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  output rd_data, rd_err, wr_err);
endinterface

// ===== rtl/ccs_top.sv
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
// How it works
// - Clearing main stop restarts main oscillator
// - Switch to main within one subclock period
// - Oscillator mode register 8-bit, resets 00H
// - Stop bit 1 halts internal oscillator
// - Mode register acts only if option allows
// - Internal oscillator kept while CPU flag set
// - Status register read-only, flag shows source
// - Watchdog overflow in stabilization sets flag
// - Peripheral clock runs only in listed states
// - PLL clock stops in reset, STOP, oscillator-off
// - PLL starts at half stabilization, then locks
// - PLL runs in light idle, stops deep
// - Watchdog oscillator clock runs except reset
// - Source flag 0 main, 1 subclock
// - Main oscillator stops in STOP or stop-on-sub
module ccs_top
    import ccs_pkg::*;
#(
    parameter int OST_CNT = OST_CYCLES,
    parameter int LOCK_CNT = LOCK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic sub_tick,
    input wire logic wdt_overflow,
    input wire logic opt_int_osc_ctrl_en,
    input wire logic pll_mode,
    input wire logic wake_event,
    output logic main_osc_en,
    output logic int_osc_en,
    output logic pll_osc_en,
    output logic fxx_run,
    output logic fcpu_run,
    output logic fclk_run,
    output logic pll_clk_run,
    output logic periph_clk_run,
    output logic wdt_int_clk_run,
    output logic wdt_main_clk_run,
    output logic [DIV_W-1:0] system_clock_divider_select
);
    ccs_reg_if rif ();
    logic [7:0] processor_clock_ctrl_ff, internal_osc_mode_ff, clk_run_status;
    logic internal_osc_cpu_flag_ff, prot_armed_ff, out_valid_ff;
    ccs_cpu_src_e cpu_src_ff;
    ccs_standby_e stby_ff;
    logic [31:0] ost_cnt_ff, lock_cnt_ff;
    logic main_osc_run, pll_locked, half_ost, ost_done, pcc_wr, cpu_sub_select, main_osc_stop;
    // ****************************************
    // Bus slave
    // ****************************************
    ccs_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .rif(rif.slave)
    );
    // Offsets known to the block
    function automatic logic is_mapped(input logic [7:0] a);
        return a == OFF_PROC_CLK_CTRL || a == OFF_INT_OSC_MODE
            || a == OFF_CPU_CLK_STATUS || a == OFF_PROT_CMD
            || a == OFF_STANDBY_CTRL || a == OFF_CLK_RUN_STATUS;
    endfunction
    // Standby code from a written byte; unknown codes mean no standby
    function automatic ccs_standby_e to_standby(input logic [STBY_W-1:0] c);
        unique case (c)
            3'h1: return SB_HALT;
            3'h2: return SB_LIGHT_IDLE_STANDBY;
            3'h3: return SB_DEEP_IDLE_STANDBY;
            3'h4: return SB_STOP;
            default: return SB_NORMAL;
        endcase
    endfunction
    assign rif.wr_err = !is_mapped(rif.wr_addr);
    assign rif.rd_err = !is_mapped(rif.rd_addr);
    assign cpu_sub_select = processor_clock_ctrl_ff[BIT_SUB_SEL];
    assign main_osc_stop = processor_clock_ctrl_ff[BIT_MAIN_OSC_STOP];
    assign pcc_wr = rif.wr_en && rif.wr_addr == OFF_PROC_CLK_CTRL && prot_armed_ff;
    // ****************************************
    // Register file
    // ****************************************
    // Read mux; the source flag is live state, not stored bits
    always_comb begin
        rif.rd_data = 8'h00;
        unique case (rif.rd_addr)
            OFF_PROC_CLK_CTRL: begin
                rif.rd_data = processor_clock_ctrl_ff;
                rif.rd_data[BIT_CLK_SRC_FLAG] = (cpu_src_ff == CPU_SUB);
            end
            OFF_INT_OSC_MODE: rif.rd_data = internal_osc_mode_ff;
            OFF_CPU_CLK_STATUS: begin
                rif.rd_data[BIT_INT_OSC_CPU_FLAG] = internal_osc_cpu_flag_ff;
            end
            OFF_STANDBY_CTRL: rif.rd_data = {5'h00, stby_ff};
            OFF_CLK_RUN_STATUS: rif.rd_data = clk_run_status;
            default: rif.rd_data = 8'h00;
        endcase
    end
    // Protection latch: armed by the command write, spent by the next write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prot_armed_ff <= 1'b0;
        end else if (rif.wr_en) begin
            prot_armed_ff <= (rif.wr_addr == OFF_PROT_CMD);
        end
    end
    // Clock control; unprotected writes are dropped silently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            processor_clock_ctrl_ff <= RST_PROC_CLK_CTRL;
        end else if (pcc_wr) begin
            processor_clock_ctrl_ff <= rif.wr_data & PROC_CLK_CTRL_WMASK;
        end
    end
    // Oscillator mode register, whole byte writable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            internal_osc_mode_ff <= RST_INT_OSC_MODE;
        end else if (rif.wr_en && rif.wr_addr == OFF_INT_OSC_MODE) begin
            internal_osc_mode_ff <= rif.wr_data;
        end
    end
    // Flag is sticky until reset; only the watchdog during stabilization sets it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            internal_osc_cpu_flag_ff <= 1'b0;
        end else if (cpu_src_ff == CPU_OST && wdt_overflow) begin
            internal_osc_cpu_flag_ff <= 1'b1;
        end
    end
    // Standby entry by write, exit by wake; wake wins over a same-cycle entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stby_ff <= SB_NORMAL;
        end else if (wake_event) begin
            stby_ff <= SB_NORMAL;
        end else if (rif.wr_en && rif.wr_addr == OFF_STANDBY_CTRL
                     && cpu_src_ff != CPU_OST) begin
            stby_ff <= to_standby(rif.wr_data[STBY_W-1:0]);
        end
    end
    // ****************************************
    // Stabilization and PLL lockup counters
    // ****************************************
    assign half_ost = ost_cnt_ff >= 32'(OST_CNT / 2);
    assign ost_done = ost_cnt_ff >= 32'(OST_CNT - 1);
    assign pll_locked = lock_cnt_ff >= 32'(LOCK_CNT);
    // Count restarts on every entry to stabilization
    always_ff @(posedge aclk) begin
        if (!aresetn || cpu_src_ff != CPU_OST) begin
            ost_cnt_ff <= 32'h0000_0000;
        end else if (!ost_done) begin
            ost_cnt_ff <= ost_cnt_ff + 32'h0000_0001;
        end
    end

    // Lockup starts once the PLL oscillates; lost whenever main osc stops
    always_ff @(posedge aclk) begin
        if (!aresetn || !main_osc_run || stby_ff == SB_DEEP_IDLE_STANDBY) begin
            lock_cnt_ff <= 32'h0000_0000;
        end else if ((cpu_src_ff != CPU_OST || half_ost) && !pll_locked) begin
            lock_cnt_ff <= lock_cnt_ff + 32'h0000_0001;
        end
    end

    // ****************************************
    // CPU clock source sequencer
    // ****************************************
    // Main/sub switches happen only at a subclock edge, so at most one subclock period late
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_src_ff <= CPU_OST;
        end else begin
            unique case (cpu_src_ff)
                CPU_OST: begin
                    if (wdt_overflow) begin
                        cpu_src_ff <= CPU_INT;
                    end else if (ost_done) begin
                        cpu_src_ff <= CPU_MAIN;
                    end
                end
                CPU_MAIN: begin
                    if (stby_ff == SB_STOP && wake_event) begin
                        cpu_src_ff <= CPU_OST;
                    end else if (cpu_sub_select && sub_tick && stby_ff == SB_NORMAL) begin
                        cpu_src_ff <= CPU_SUB;
                    end
                end
                CPU_SUB: begin
                    if (!cpu_sub_select && sub_tick) begin
                        cpu_src_ff <= CPU_MAIN;
                    end
                end
                CPU_INT: cpu_src_ff <= CPU_INT;
            endcase
        end
    end

    // ****************************************
    // Derived clock gating
    // ****************************************
    // Stop bit only bites once the CPU runs on the subclock
    assign main_osc_run = stby_ff != SB_STOP
        && !(main_osc_stop && cpu_src_ff == CPU_SUB);
    // Next-state gates from source and standby mode
    logic nxt_main_osc_en, nxt_int_osc_en, nxt_pll_osc_en, nxt_fxx_run, nxt_fcpu_run;
    logic nxt_fclk_run, nxt_pll_clk_run, nxt_periph_clk_run;
    always_comb begin
        nxt_main_osc_en = main_osc_run;
        // Option gates the stop bit; CPU on the internal osc overrides it
        nxt_int_osc_en = !(opt_int_osc_ctrl_en
            && internal_osc_mode_ff[BIT_INT_OSC_STOP]
            && !internal_osc_cpu_flag_ff);
        nxt_pll_osc_en = 1'b0;
        nxt_fxx_run = 1'b0;
        nxt_fcpu_run = 1'b0;
        nxt_fclk_run = 1'b0;
        nxt_pll_clk_run = 1'b0;
        nxt_periph_clk_run = 1'b0;
        unique case (cpu_src_ff)
            CPU_OST: begin
                nxt_pll_osc_en = half_ost;
                nxt_pll_clk_run = half_ost && pll_locked;
            end
            CPU_MAIN: begin
                nxt_pll_osc_en = main_osc_run && stby_ff != SB_DEEP_IDLE_STANDBY;
                nxt_fxx_run = stby_ff inside {SB_NORMAL, SB_HALT};
                nxt_fcpu_run = stby_ff == SB_NORMAL;
                nxt_fclk_run = stby_ff inside {SB_NORMAL, SB_HALT};
                nxt_periph_clk_run = stby_ff inside {SB_NORMAL, SB_HALT};
                nxt_pll_clk_run = main_osc_run && pll_locked
                    && stby_ff inside {SB_NORMAL, SB_HALT, SB_LIGHT_IDLE_STANDBY};
            end
            CPU_SUB: begin
                nxt_pll_osc_en = main_osc_run;
                nxt_fxx_run = main_osc_run && stby_ff == SB_NORMAL;
                nxt_fcpu_run = stby_ff == SB_NORMAL;
                nxt_fclk_run = stby_ff == SB_NORMAL;
                nxt_periph_clk_run = main_osc_run && stby_ff == SB_NORMAL;
                nxt_pll_clk_run = main_osc_run && pll_locked;
            end
            CPU_INT: begin
                nxt_fcpu_run = stby_ff == SB_NORMAL;
                nxt_fclk_run = stby_ff inside {SB_NORMAL, SB_HALT};
            end
        endcase
        nxt_pll_clk_run = nxt_pll_clk_run && pll_mode;
    end

    // All gates held off during reset, then follow the next-state terms; the watchdog oscillator clock is simply on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid_ff <= 1'b0;
            main_osc_en <= 1'b0;
            int_osc_en <= 1'b0;
            pll_osc_en <= 1'b0;
            fxx_run <= 1'b0;
            fcpu_run <= 1'b0;
            fclk_run <= 1'b0;
            pll_clk_run <= 1'b0;
            periph_clk_run <= 1'b0;
            wdt_int_clk_run <= 1'b0;
            wdt_main_clk_run <= 1'b0;
        end else begin
            out_valid_ff <= 1'b1;
            main_osc_en <= nxt_main_osc_en;
            int_osc_en <= nxt_int_osc_en;
            pll_osc_en <= nxt_pll_osc_en;
            fxx_run <= nxt_fxx_run;
            fcpu_run <= nxt_fcpu_run;
            fclk_run <= nxt_fclk_run;
            pll_clk_run <= nxt_pll_clk_run;
            periph_clk_run <= nxt_periph_clk_run;
            wdt_int_clk_run <= 1'b1;
            wdt_main_clk_run <= nxt_periph_clk_run;
        end
    end

    assign system_clock_divider_select = processor_clock_ctrl_ff[DIV_LSB +: DIV_W];
    assign clk_run_status = {wdt_main_clk_run, wdt_int_clk_run, periph_clk_run,
        pll_clk_run, fclk_run, fcpu_run, fxx_run, main_osc_en};

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_prot_clear_mck;
        prot_armed_ff && rif.wr_en && rif.wr_addr == OFF_PROC_CLK_CTRL
            && !rif.wr_data[BIT_MAIN_OSC_STOP];
    endsequence
    sequence s_sub_release;
        cpu_src_ff == CPU_SUB && !cpu_sub_select && sub_tick && stby_ff != SB_STOP;
    endsequence
    a_main_restart: assert property (s_prot_clear_mck ##0 stby_ff != SB_STOP
        |=> ##1 main_osc_en)
        else $error("main oscillator not restarted after stop bit cleared");
    a_sub_to_main: assert property (s_sub_release |=> cpu_src_ff == CPU_MAIN
        ##0 (!rif.rd_data[BIT_CLK_SRC_FLAG] || rif.rd_addr != OFF_PROC_CLK_CTRL))
        else $error("CPU not back on main clock at subclock edge");
    a_unprot_write: assert property (rif.wr_en && rif.wr_addr == OFF_PROC_CLK_CTRL
        && !prot_armed_ff |=> $stable(processor_clock_ctrl_ff))
        else $error("control register changed without release command");
    a_int_osc_kept: assert property (internal_osc_cpu_flag_ff [*2]
        |-> int_osc_en)
        else $error("internal oscillator stopped while CPU runs on it");
    a_int_osc_stop: assert property (opt_int_osc_ctrl_en
        && internal_osc_mode_ff[BIT_INT_OSC_STOP] && !internal_osc_cpu_flag_ff
        |=> !int_osc_en)
        else $error("internal oscillator runs with stop bit set");
    a_wdt_switch: assert property (cpu_src_ff == CPU_OST && wdt_overflow
        |=> internal_osc_cpu_flag_ff && cpu_src_ff == CPU_INT)
        else $error("watchdog overflow did not move CPU to internal oscillator");
    a_periph_idle: assert property (stby_ff inside {SB_LIGHT_IDLE_STANDBY, SB_DEEP_IDLE_STANDBY, SB_STOP}
        |=> !periph_clk_run)
        else $error("peripheral clock running in idle or stop");
    a_pll_deep_idle: assert property (stby_ff inside {SB_DEEP_IDLE_STANDBY, SB_STOP} [*2]
        |-> !pll_clk_run)
        else $error("PLL clock running in deep idle or stop");
    a_pll_half_ost: assert property (cpu_src_ff == CPU_OST && !half_ost
        |=> !pll_osc_en && !pll_clk_run)
        else $error("PLL started before half the stabilization time");
    a_wdt_clk_run: assert property (out_valid_ff |-> wdt_int_clk_run)
        else $error("watchdog oscillator clock stopped outside reset");
    a_main_stop_sub: assert property (cpu_src_ff == CPU_SUB && main_osc_stop
        |=> !main_osc_en)
        else $error("main oscillator still running with stop bit on subclock");
endmodule

// ===== tb/ccs_testbench.sv
`timescale 1ns/1ns
module testbench;
    import ccs_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic bready = 1, rready = 1, sub_tick = 0, wdt_overflow = 0;
    logic opt_en = 1, pll_mode = 1, wake_event = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_v;
    logic [1:0] bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid;
    logic main_osc_en, int_osc_en, fcpu_run, periph_clk_run, pll_clk_run, wdt_int_clk_run;
    logic [2:0] div_sel;
    int err_count = 0, checks = 0;
    ccs_top #(.OST_CNT(16), .LOCK_CNT(4)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .sub_tick(sub_tick), .wdt_overflow(wdt_overflow), .opt_int_osc_ctrl_en(opt_en),
        .pll_mode(pll_mode), .wake_event(wake_event), .main_osc_en(main_osc_en),
        .int_osc_en(int_osc_en), .pll_osc_en(), .fxx_run(), .fcpu_run(fcpu_run),
        .fclk_run(), .pll_clk_run(pll_clk_run), .periph_clk_run(periph_clk_run),
        .wdt_int_clk_run(wdt_int_clk_run), .wdt_main_clk_run(),
        .system_clock_divider_select(div_sel));
    // ****************************************
    // Clock, timeout, reporting
    // ****************************************
    initial begin
        forever #25 aclk = ~aclk;
    end
    // Whole run needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        conclude();
    end
    task automatic conclude();
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // ****************************************
    // Bus tasks; bready and rready stay high
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ah, wh;
        ah = 0;
        wh = 0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1;
        wvalid <= 1;
        while (!(ah && wh)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                ah = 1;
                awvalid <= 0;
            end
            if (wvalid && wready) begin
                wh = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        repeat (3) @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd_v = rdata;
        rs = rresp;
    endtask
    // Control register only accepts a write right after the release command
    task automatic pw(input logic [7:0] d);
        wr(OFF_PROT_CMD, 8'h00);
        wr(OFF_PROC_CLK_CTRL, d);
    endtask
    task automatic tick();
        sub_tick <= 1;
        @(posedge aclk);
        sub_tick <= 0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic do_reset();
        aresetn <= 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
    endtask
    task automatic wait_run();
        int n;
        n = 0;
        while (fcpu_run !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_values();
        rd(OFF_INT_OSC_MODE);
        chk("osc_mode rst", rd_v, 32'h0);
        rd(OFF_CPU_CLK_STATUS);
        chk("status rst", rd_v, 32'h0);
        wait_run();
        chk("periph run", periph_clk_run, 1'b1);
        chk("wdt int run", wdt_int_clk_run, 1'b1);
        rd(OFF_CLK_RUN_STATUS);
        chk("run status", rd_v, 32'hFF);
    endtask
    task automatic t_int_osc();
        wr(OFF_INT_OSC_MODE, 8'h01);
        chk("int osc off", int_osc_en, 1'b0);
        rd(OFF_INT_OSC_MODE);
        chk("osc_mode rb", rd_v, 32'h1);
        opt_en <= 0;
        repeat (3) @(posedge aclk);
        chk("opt gate", int_osc_en, 1'b1);
        opt_en <= 1;
        wr(OFF_INT_OSC_MODE, 8'h00);
        wr(OFF_CPU_CLK_STATUS, 8'hFF);
        rd(OFF_CPU_CLK_STATUS);
        chk("status ro", rd_v, 32'h0);
        rd(8'h40);
        chk("unmapped", rs, 2'h2);
    endtask
    task automatic t_sub_main();
        pw(8'h0B);
        tick();
        rd(OFF_PROC_CLK_CTRL);
        chk("on sub", rd_v, 32'h1B);
        chk("periph sub", periph_clk_run, 1'b1);
        pw(8'h4B);
        chk("main stop", main_osc_en, 1'b0);
        chk("pll stop", pll_clk_run, 1'b0);
        pw(8'h0B);
        chk("main restart", main_osc_en, 1'b1);
        repeat (16) @(posedge aclk);
        pw(8'h03);
        tick();
        rd(OFF_PROC_CLK_CTRL);
        chk("back main", rd_v, 32'h03);
        chk("divider", div_sel, 3'h3);
        wr(OFF_PROC_CLK_CTRL, 8'h0B);
        rd(OFF_PROC_CLK_CTRL);
        chk("unprotected", rd_v, 32'h03);
    endtask
    task automatic t_stop();
        wr(OFF_STANDBY_CTRL, 8'h02);
        rd(OFF_CLK_RUN_STATUS);
        chk("light_idle_standby run", rd_v, 32'h51);
        wake_event <= 1;
        @(posedge aclk);
        wake_event <= 0;
        wr(OFF_STANDBY_CTRL, 8'h04);
        rd(OFF_CLK_RUN_STATUS);
        chk("stop run", rd_v, 32'h40);
        chk("stop periph", periph_clk_run, 1'b0);
        chk("stop wdt", wdt_int_clk_run, 1'b1);
        wake_event <= 1;
        @(posedge aclk);
        wake_event <= 0;
        wait_run();
    endtask
    task automatic t_wdt_flag();
        do_reset();
        wdt_overflow <= 1;
        @(posedge aclk);
        wdt_overflow <= 0;
        rd(OFF_CPU_CLK_STATUS);
        chk("flag set", rd_v, {24'h0, CPU_STATUS_INT_OSC});
        wr(OFF_INT_OSC_MODE, 8'h01);
        chk("osc kept", int_osc_en, 1'b1);
        rd(OFF_INT_OSC_MODE);
        chk("stop kept", rd_v, 32'h1);
    endtask
    initial begin
        do_reset();
        t_reset_values();
        t_int_osc();
        t_sub_main();
        t_stop();
        t_wdt_flag();
        conclude();
    end
endmodule
